// ===== inc/kfc_pkg.sv
package kfc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_FIFO = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h01;
  localparam logic [7:0] ADDR_DEB = 8'h02;
  localparam logic [7:0] ADDR_INT = 8'h03;
  localparam logic [7:0] ADDR_RPT = 8'h05;
  localparam logic [7:0] ADDR_SLP = 8'h06;
  localparam logic [7:0] ADDR_SIZE = 8'h30;

  // power-up values
  localparam logic [7:0] RST_CFG = 8'h0B;
  localparam logic [7:0] RST_DEB = 8'hFF;
  localparam logic [7:0] RST_INT = 8'h00;
  localparam logic [7:0] RST_RPT = 8'h00;
  localparam logic [7:0] RST_SLP = 8'h07;
  localparam logic [7:0] RST_SIZE = 8'hFF;

  // special fifo bytes
  localparam logic [7:0] BYTE_EMPTY = 8'h3F;
  localparam logic [7:0] BYTE_OVF = 8'h7F;
  localparam logic [6:0] CODE_REPEAT = 7'h7E;
  localparam logic [5:0] KEY_SHARED = 6'h3E;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 128_000;
  localparam int TICK_HZ = OSC_HZ / 2;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int DEB_STEP_US = 2000;
  localparam int DEB_STEP_TICKS = DEB_STEP_US * TICK_HZ / 1_000_000;
  localparam int WAKE_US = 2000;
  localparam int WAKE_TICKS = WAKE_US * TICK_HZ / 1_000_000;
  localparam int SLEEP_UNIT_TICKS = 8192;
  localparam int RPT_DELAY_STEP = 8;
  localparam int RPT_RATE_STEP = 4;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic release_ev;
    logic [5:0] key;
  } kfc_evt_s;

  typedef struct packed {
    logic run;
    logic rsv6;
    logic iclr;
    logic rsv4;
    logic rel_en;
    logic rsv2;
    logic wake_en;
    logic tmo_en;
  } kfc_cfg_s;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_WARM,
    ST_SCAN
  } kfc_mode_e;

endpackage

// ===== logic/kfc_evt_mem.sv
`timescale 1ns/10ps
module kfc_evt_mem #(
  parameter int W = 7,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem_q [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem_q[raddr];
    end
  end

endmodule

// ===== logic/kfc_keyscan.sv
`timescale 1ns/10ps
// Contract
// [R1] event low six bits: column*8 + row
// [R2] bit7 flags more events, not keys 62/63
// [R3] bit6 marks press or release
// [R4] host rereads after key 62 or 63
// [R5] fifo read clears interrupt per mode bit
// [R6] run bit written by host, updated automatically
// [R7] low nibble press, high release debounce
// [R8] timing from 64kHz tick of 128kHz
// [R9] interrupt register zero means never interrupt
// [R10] timed interrupt after 1-31 debounce cycles
// [R11] fill interrupt at 2-14 queued events
// [R12] either interrupt source, first wins
// [R13] held key queues repeat code only
// [R14] repeat enable, delay and rate fields
// [R15] one repeat per interval, ends at event
// [R16] restart repeat delay after release
// [R17] idle timeout enters sleep, fifo kept
// [R18] array size selects scanned rows, columns
// [R19] wake by host write or keypress
// [R20] waking key still queued; autowake disable bit
// [R21] sixteen deep, overflow byte read first
// [R22] eighteenth event release clears overflow
// [R23] one byte read: event plus status
// [R24] reset enters sleep, scanning stopped
// [R25] event only if stable across debounce
module kfc_keyscan #(
  parameter int OSC_DIV = kfc_pkg::OSC_DIV,
  parameter int SLEEP_UNIT = kfc_pkg::SLEEP_UNIT_TICKS,
  parameter int DEPTH = kfc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // key matrix, rows active low with pull-ups
  input wire logic [7:0] matrix_line_r,
  output logic [7:0] matrix_line_c_o,
  output logic [7:0] matrix_line_c_oe_n,
  // interrupt
  output logic int_n
);

  localparam int AW = $clog2(DEPTH);

  function automatic logic [7:0] line_mask(input logic [3:0] n);
    logic [7:0] m;
    m = (n >= 4'h8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
    return m;
  endfunction

  function automatic logic [5:0] first_set(input logic [63:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // 64kHz tick
  logic [15:0] div_q;
  logic half_q;
  logic tick;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
      half_q <= 1'b0;
    end else if (div_q == 16'(OSC_DIV - 1)) begin
      div_q <= '0;
      half_q <= ~half_q;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign tick = (div_q == 16'(OSC_DIV - 1)) && half_q; // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // row synchroniser
  logic [7:0] row_s1_q;
  logic [7:0] row_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_s1_q <= 8'hFF;
      row_q <= 8'hFF;
    end else begin
      row_s1_q <= matrix_line_r;
      row_q <= row_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  kfc_pkg::kfc_cfg_s cfg_q;
  kfc_pkg::kfc_mode_e mode_q;
  logic [7:0] deb_q;
  logic [7:0] intc_q;
  logic [7:0] rpt_q;
  logic [7:0] slp_q;
  logic [7:0] size_q;
  logic [7:0] row_msk;
  logic [7:0] col_msk;
  logic sleep_fire;
  logic wake_fire;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_q <= kfc_pkg::RST_DEB;
      intc_q <= kfc_pkg::RST_INT;
      rpt_q <= kfc_pkg::RST_RPT;
      slp_q <= kfc_pkg::RST_SLP;
      size_q <= kfc_pkg::RST_SIZE;
    end else if (reg_wr) begin
      case (reg_addr)
        kfc_pkg::ADDR_DEB: deb_q <= reg_wdata; // [R7]
        kfc_pkg::ADDR_INT: intc_q <= reg_wdata;
        kfc_pkg::ADDR_RPT: rpt_q <= reg_wdata; // [R14]
        kfc_pkg::ADDR_SLP: slp_q <= reg_wdata;
        kfc_pkg::ADDR_SIZE: size_q <= reg_wdata; // [R18]
        default: ;
      endcase
    end
  end

  // host write wins over an automatic mode change in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= kfc_pkg::kfc_cfg_s'(kfc_pkg::RST_CFG); // [R24]
    end else if (reg_wr && reg_addr == kfc_pkg::ADDR_CFG) begin
      cfg_q <= kfc_pkg::kfc_cfg_s'(reg_wdata); // [R6]
    end else if (sleep_fire) begin
      cfg_q.run <= 1'b0; // [R6]
    end else if (wake_fire) begin
      cfg_q.run <= 1'b1; // [R6]
    end
  end

  assign row_msk = line_mask(size_q[7:4]); // [R18]
  assign col_msk = line_mask(size_q[3:0]); // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // mode: sleep, analog warm-up, scanning
  logic [7:0] warm_q;

  assign wake_fire = (mode_q == kfc_pkg::ST_SLEEP) && !cfg_q.run && cfg_q.wake_en
                     && |(~row_q & row_msk); // [R19] [R20]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= kfc_pkg::ST_SLEEP; // [R24]
      warm_q <= '0;
    end else begin
      case (mode_q)
        kfc_pkg::ST_SLEEP: begin
          warm_q <= '0;
          if (cfg_q.run || wake_fire) begin
            mode_q <= kfc_pkg::ST_WARM; // [R19]
          end
        end
        kfc_pkg::ST_WARM: begin
          if (!cfg_q.run) begin
            mode_q <= kfc_pkg::ST_SLEEP;
          end else if (tick) begin
            warm_q <= warm_q + 8'h01;
            if (warm_q == 8'(kfc_pkg::WAKE_TICKS - 1)) begin
              mode_q <= kfc_pkg::ST_SCAN; // [R20]
            end
          end
        end
        kfc_pkg::ST_SCAN: begin
          if (!cfg_q.run) begin
            mode_q <= kfc_pkg::ST_SLEEP; // [R6]
          end
        end
        default: mode_q <= kfc_pkg::ST_SLEEP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // column drive and row capture, one column per tick
  logic [2:0] col_q;
  logic [63:0] raw_q;
  logic scan_done_q;
  logic [63:0] key_mask;
  logic [63:0] cur;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_q <= '0;
      raw_q <= '0;
      scan_done_q <= 1'b0;
      matrix_line_c_oe_n <= 8'hFF;
    end else if (mode_q != kfc_pkg::ST_SCAN) begin
      col_q <= '0;
      scan_done_q <= 1'b0;
      // in sleep with wake_en set all used columns pull low so any press reaches a row
      matrix_line_c_oe_n <= (mode_q == kfc_pkg::ST_SLEEP && cfg_q.wake_en) ?
                            ~col_msk : 8'hFF;
    end else begin
      scan_done_q <= 1'b0;
      matrix_line_c_oe_n <= ~((8'h01 << col_q) & col_msk);
      if (tick) begin
        raw_q[col_q*8 +: 8] <= ~row_q & row_msk;
        col_q <= col_q + 3'h1;
        scan_done_q <= (col_q == 3'h7);
      end
    end
  end

  assign matrix_line_c_o = 8'h00;

  for (genvar c = 0; c < 8; c++) begin : g_col
    for (genvar r = 0; r < 8; r++) begin : g_row
      assign key_mask[c*8+r] = col_msk[c] & row_msk[r]; // [R1] [R18]
    end
  end

  assign cur = raw_q & key_mask;

  ////////////////////////////////////////////////////////////////////////////
  // debounce: snapshot at change, compare after the interval
  logic [63:0] stable_q;
  logic [63:0] snap_q;
  logic [63:0] pend_q;
  logic busy_q;
  logic [11:0] dcnt_q;
  logic [11:0] dlen_q;
  logic [11:0] press_len;
  logic [11:0] rel_len;
  logic decide;
  logic accept;
  logic emit;
  logic erel;
  logic [5:0] eidx;

  assign press_len = 12'((32'(deb_q[3:0]) + 1) * kfc_pkg::DEB_STEP_TICKS); // [R7]
  assign rel_len = 12'((32'(deb_q[7:4]) + 1) * kfc_pkg::DEB_STEP_TICKS); // [R7]
  assign decide = busy_q && scan_done_q && (dcnt_q >= dlen_q);
  assign accept = decide && (cur == snap_q); // [R25]
  assign emit = |pend_q;
  assign eidx = first_set(pend_q); // [R1]
  assign erel = ~stable_q[eidx]; // [R3]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_q <= '0;
      snap_q <= '0;
      pend_q <= '0;
      busy_q <= 1'b0;
      dcnt_q <= '0;
      dlen_q <= '0;
    end else begin
      pend_q <= (pend_q & ~(emit ? (64'h1 << eidx) : 64'h0))
                | (accept ? (snap_q ^ stable_q) : 64'h0);
      if (mode_q != kfc_pkg::ST_SCAN) begin
        busy_q <= 1'b0;
        dcnt_q <= '0;
      end else if (!busy_q) begin
        if (scan_done_q && cur != stable_q) begin
          busy_q <= 1'b1;
          snap_q <= cur;
          dcnt_q <= '0;
          dlen_q <= |(cur & ~stable_q) ? press_len : rel_len; // [R7]
        end
      end else begin
        if (tick) begin
          dcnt_q <= dcnt_q + 12'h001; // [R8]
        end
        if (decide) begin
          busy_q <= 1'b0;
        end
        if (accept) begin
          stable_q <= snap_q; // [R25]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debounce cycle strobe for repeat and timed interrupt
  logic [11:0] cyc_q;
  logic db_cyc;

  assign db_cyc = tick && (mode_q == kfc_pkg::ST_SCAN) && (cyc_q == press_len - 12'h001);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
    end else if (mode_q != kfc_pkg::ST_SCAN || db_cyc) begin
      cyc_q <= '0;
    end else if (tick) begin
      cyc_q <= cyc_q + 12'h001; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event stream and autorepeat
  logic kev_push;
  logic rpt_push;
  logic push;
  kfc_pkg::kfc_evt_s pdata;
  logic [7:0] rcnt_q;
  logic rfirst_q;
  logic rpt_req_q;
  logic [7:0] rtarget;

  // a release with release detection off is dropped, not queued
  assign kev_push = emit && (!erel || cfg_q.rel_en); // [R3]
  assign rpt_push = rpt_req_q && !emit;
  assign push = kev_push || rpt_push;
  assign pdata = rpt_push ? kfc_pkg::kfc_evt_s'(kfc_pkg::CODE_REPEAT) :
                 kfc_pkg::kfc_evt_s'({erel, eidx}); // [R13] [R1] [R3]
  assign rtarget = rfirst_q ?
                   8'((32'(rpt_q[3:0]) + 1) * kfc_pkg::RPT_DELAY_STEP) :
                   8'((32'(rpt_q[6:4]) + 1) * kfc_pkg::RPT_RATE_STEP); // [R14]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= '0;
      rfirst_q <= 1'b1;
      rpt_req_q <= 1'b0;
    end else if (kev_push || !(|stable_q) || !rpt_q[7]) begin
      rcnt_q <= '0;
      rfirst_q <= 1'b1; // [R16]
      rpt_req_q <= 1'b0; // [R15]
    end else begin
      if (rpt_push) begin
        rpt_req_q <= 1'b0;
      end
      if (db_cyc) begin
        if (rcnt_q + 8'h01 == rtarget) begin
          rcnt_q <= '0;
          rfirst_q <= 1'b0;
          rpt_req_q <= 1'b1; // [R13] [R15]
        end else begin
          rcnt_q <= rcnt_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event fifo with overflow marking
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic ovf_q;
  logic [1:0] ext_q;
  logic full;
  logic fifo_rd;
  logic pop;
  logic wr_ok;
  logic fresh_q;
  kfc_pkg::kfc_evt_s head;

  assign full = (cnt_q == (AW+1)'(DEPTH)); // [R21]
  assign fifo_rd = reg_rd && (reg_addr == kfc_pkg::ADDR_FIFO);
  assign pop = fifo_rd && !ovf_q && (cnt_q != '0) && !fresh_q;
  assign wr_ok = push && !full;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      fresh_q <= 1'b0;
    end else begin
      // the registered head lags a write into an empty fifo by one clock
      fresh_q <= wr_ok && (cnt_q == '0);
      if (wr_ok) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr_ok) - (AW+1)'(pop);
    end
  end

  // the overflow byte is shown once and then the stored events follow
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      ext_q <= '0;
    end else begin
      if (!full) begin
        ext_q <= '0;
      end
      if (fifo_rd && ovf_q) begin
        ovf_q <= 1'b0;
      end
      if (wr_ok && !cfg_q.rel_en && cnt_q == (AW+1)'(DEPTH - 1)) begin
        ovf_q <= 1'b1; // [R21]
      end
      if (push && full) begin
        ext_q <= (ext_q == 2'h3) ? ext_q : ext_q + 2'h1;
        ovf_q <= 1'b1; // [R21]
        if (ext_q == 2'h1 && kev_push && erel) begin
          ovf_q <= 1'b0; // [R22]
        end
      end
    end
  end

  kfc_evt_mem #(
    .W(7),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(wr_ok),
    .waddr(wptr_q),
    .wdata(pdata),
    .raddr(rptr_q),
    .rdata(head)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        kfc_pkg::ADDR_FIFO: begin
          if (ovf_q) begin
            reg_rdata <= kfc_pkg::BYTE_OVF; // [R21]
          end else if (cnt_q == '0 || fresh_q) begin
            reg_rdata <= kfc_pkg::BYTE_EMPTY;
          end else begin
            // keys 62 and 63 carry no more-data flag, so the host reads again
            reg_rdata <= {(cnt_q > (AW+1)'(1)) && (head.key < kfc_pkg::KEY_SHARED),
                          head}; // [R2] [R4] [R23]
          end
        end
        kfc_pkg::ADDR_CFG: reg_rdata <= cfg_q; // [R6]
        kfc_pkg::ADDR_DEB: reg_rdata <= deb_q;
        kfc_pkg::ADDR_INT: reg_rdata <= intc_q;
        kfc_pkg::ADDR_RPT: reg_rdata <= rpt_q;
        kfc_pkg::ADDR_SLP: reg_rdata <= slp_q;
        kfc_pkg::ADDR_SIZE: reg_rdata <= size_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt
  logic [4:0] tcnt_q;
  logic tarm_q;
  logic int_q;
  logic tfire;
  logic lfire;
  logic [AW:0] lvl;

  assign lvl = (AW+1)'({intc_q[7:5], 1'b0}); // [R11]
  assign tfire = tarm_q && db_cyc && (tcnt_q + 5'h01 == intc_q[4:0]); // [R10]
  assign lfire = (intc_q[7:5] != 3'h0) && wr_ok && !pop
                 && (cnt_q == lvl - (AW+1)'(1)); // [R11]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_q <= '0;
      tarm_q <= 1'b0;
    end else if (push) begin
      tcnt_q <= '0;
      tarm_q <= (intc_q[4:0] != 5'h00); // [R10]
    end else if (tfire) begin
      tarm_q <= 1'b0;
    end else if (db_cyc && tarm_q) begin
      tcnt_q <= tcnt_q + 5'h01;
    end
  end

  // set wins over a clearing read in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 1'b0;
    end else if (intc_q == 8'h00) begin
      int_q <= 1'b0; // [R9]
    end else if (tfire || lfire) begin
      int_q <= 1'b1; // [R12]
    end else if (fifo_rd && (!cfg_q.iclr || cnt_q <= (AW+1)'(1))) begin
      int_q <= 1'b0; // [R5]
    end
  end

  assign int_n = ~int_q;

  ////////////////////////////////////////////////////////////////////////////
  // autosleep after key inactivity
  logic [19:0] idle_q;

  assign sleep_fire = (mode_q == kfc_pkg::ST_SCAN) && (slp_q[2:0] != 3'h0)
                      && (idle_q >= 20'(32'(slp_q[2:0]) * SLEEP_UNIT)); // [R17]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
    end else if (mode_q != kfc_pkg::ST_SCAN || |stable_q || busy_q || emit) begin
      idle_q <= '0;
    end else if (tick && !sleep_fire) begin
      idle_q <= idle_q + 20'h00001; // [R17]
    end
  end

endmodule

// ===== verif/kfc_keyscan_checker.sv
`timescale 1ns/10ps
module kfc_keyscan_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // key matrix
  input wire logic [7:0] matrix_line_r,
  input wire logic [7:0] matrix_line_c_o,
  input wire logic [7:0] matrix_line_c_oe_n,
  // interrupt
  input wire logic int_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] deb_q;
  logic [7:0] int_cfg_q;
  logic iclr_q;
  logic fifo_rd;
  logic int_wr;
  assign fifo_rd = reg_rd && reg_addr == kfc_pkg::ADDR_FIFO;
  assign int_wr = reg_wr && reg_addr == kfc_pkg::ADDR_INT;
  ////////////////////////////////////////////////////////////////////////////
  // host-owned fields only; autosleep never touches these bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_q <= kfc_pkg::RST_DEB;
      int_cfg_q <= kfc_pkg::RST_INT;
      iclr_q <= kfc_pkg::RST_CFG[5];
    end else if (reg_wr) begin
      if (reg_addr == kfc_pkg::ADDR_DEB) deb_q <= reg_wdata;
      if (reg_addr == kfc_pkg::ADDR_INT) int_cfg_q <= reg_wdata;
      if (reg_addr == kfc_pkg::ADDR_CFG) iclr_q <= reg_wdata[5];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_col_out_zero: assert property (matrix_line_c_o == 8'h00)
    else $error("column output value not low");
  a_deb_read_back: assert property (reg_rd && reg_addr == kfc_pkg::ADDR_DEB
    |=> reg_rdata == deb_q) else $error("debounce register read back wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_int_off_zero: assert property (int_cfg_q == 8'h00 && $past(int_cfg_q) == 8'h00
    && $past(int_cfg_q, 2) == 8'h00 |-> int_n) else $error("interrupt while disabled");
  a_int_fire_cfg: assert property ($fell(int_n) |-> $past(int_cfg_q) != 8'h00)
    else $error("interrupt without trigger setup");
  a_int_read_clear: assert property (fifo_rd && !iclr_q && !int_n |-> ##[1:2] int_n)
    else $error("fifo read left interrupt asserted");
  a_int_holds_low: assert property (!int_n && !fifo_rd && !$past(fifo_rd) && !int_wr
    && !$past(int_wr) |=> !int_n) else $error("interrupt released without cause");
endmodule
bind kfc_keyscan kfc_keyscan_checker kfc_keyscan_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .matrix_line_r(matrix_line_r), .matrix_line_c_o(matrix_line_c_o),
  .matrix_line_c_oe_n(matrix_line_c_oe_n), .int_n(int_n));

// ===== verif/kfc_keyscan_tb_top.sv
`timescale 1ns/10ps
module kfc_keyscan_tb_top;
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] matrix_line_r;
  logic [7:0] matrix_line_c_o;
  logic [7:0] matrix_line_c_oe_n;
  logic int_n;
  logic [63:0] key_down;
  logic [7:0] d;
  int n_mismatch;
  int samples_checked;
  localparam logic [7:0] RV_ADDR [0:7] = '{kfc_pkg::ADDR_FIFO, kfc_pkg::ADDR_CFG,
    kfc_pkg::ADDR_DEB, kfc_pkg::ADDR_INT, kfc_pkg::ADDR_RPT, kfc_pkg::ADDR_SLP,
    kfc_pkg::ADDR_SIZE, 8'h04};
  localparam logic [7:0] RV_EXP [0:7] = '{kfc_pkg::BYTE_EMPTY, kfc_pkg::RST_CFG,
    kfc_pkg::RST_DEB, kfc_pkg::RST_INT, kfc_pkg::RST_RPT, kfc_pkg::RST_SLP,
    kfc_pkg::RST_SIZE, 8'h00};
  ////////////////////////////////////////////////////////////////////////////
  // short tick and sleep unit keep each debounce near a thousand clocks
  kfc_keyscan #(.OSC_DIV(4), .SLEEP_UNIT(16), .DEPTH(16)) kfc_keyscan_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .matrix_line_r(matrix_line_r), .matrix_line_c_o(matrix_line_c_o),
    .matrix_line_c_oe_n(matrix_line_c_oe_n), .int_n(int_n));
  kfc_matrix_model kfc_matrix_model_i (.col_o(matrix_line_c_o),
    .col_oe_n(matrix_line_c_oe_n), .key_down(key_down), .row(matrix_line_r));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checked %0d values, %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  // three cycles per read also keeps fifo reads spaced as the port needs
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic wait_ev(output logic [7:0] v);
    v = kfc_pkg::BYTE_EMPTY;
    for (int k = 0; k < 2000 && v === kfc_pkg::BYTE_EMPTY; k++) rd(kfc_pkg::ADDR_FIFO, v);
  endtask
  task automatic wait_int;
    for (int k = 0; k < 5000 && int_n !== 1'b0; k++) @(negedge ref_clk);
  endtask
  task automatic drain;
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 40 && v !== kfc_pkg::BYTE_EMPTY; k++) rd(kfc_pkg::ADDR_FIFO, v);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #800_000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    key_down = '0;
    rst_n = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(RV_ADDR[i], d);
      chk(d, RV_EXP[i], "reset value");
    end
    wr(kfc_pkg::ADDR_FIFO, 8'h55);
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, kfc_pkg::BYTE_EMPTY, "fifo write ignored");
    $display("test reset_values done");
    wr(kfc_pkg::ADDR_DEB, 8'h00);
    wr(kfc_pkg::ADDR_CFG, 8'h8A);
    rd(kfc_pkg::ADDR_CFG, d);
    chk(d, 8'h8A, "run bit written");
    key_down[10] = 1'b1;
    wait_ev(d);
    chk(d, 8'h0A, "press key 10");
    chk({7'h00, int_n}, 8'h01, "interrupt while disabled");
    key_down[10] = 1'b0;
    wait_ev(d);
    chk(d, 8'h4A, "release key 10");
    $display("test single_key done");
    wr(kfc_pkg::ADDR_INT, 8'h20);
    key_down[3] = 1'b1;
    key_down[62] = 1'b1;
    wait_int();
    chk({7'h00, int_n}, 8'h00, "fill interrupt");
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, 8'h83, "first of two with more flag");
    chk({7'h00, int_n}, 8'h01, "read clears interrupt");
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, 8'h3E, "shared key without more flag");
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, kfc_pkg::BYTE_EMPTY, "reread after shared key");
    key_down = '0;
    repeat (3000) @(negedge ref_clk);
    drain();
    $display("test fill_interrupt done");
    // the wake from autosleep lies inside this wait, so the key must survive it
    wr(kfc_pkg::ADDR_INT, 8'h01);
    key_down[20] = 1'b1;
    wait_int();
    chk({7'h00, int_n}, 8'h00, "timed interrupt");
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, 8'h14, "waking key queued");
    chk({7'h00, int_n}, 8'h01, "read clears timed interrupt");
    wr(kfc_pkg::ADDR_INT, 8'h00);
    key_down = '0;
    repeat (3000) @(negedge ref_clk);
    drain();
    $display("test timed_interrupt done");
    // two by two array: key 10 sits on row 2 and must stay invisible
    wr(kfc_pkg::ADDR_SIZE, 8'h22);
    wr(kfc_pkg::ADDR_RPT, 8'h80);
    key_down[10:9] = 2'h3;
    wait_ev(d);
    chk(d, 8'h09, "row outside array ignored");
    // first repeat lands eight debounce cycles after the press
    repeat (6000) @(negedge ref_clk);
    wait_ev(d);
    chk(d, 8'h7E, "repeat code queued");
    key_down = '0;
    wait_ev(d);
    chk(d, 8'h49, "release ends repeat");
    repeat (2000) @(negedge ref_clk);
    rd(kfc_pkg::ADDR_CFG, d);
    chk(d, 8'h0A, "autosleep clears run bit");
    wr(kfc_pkg::ADDR_RPT, 8'h00);
    wr(kfc_pkg::ADDR_SIZE, 8'hFF);
    $display("test repeat_sleep done");
    key_down[16:0] = '1;
    repeat (3000) @(negedge ref_clk);
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, kfc_pkg::BYTE_OVF, "overflow byte first");
    for (int i = 0; i < 16; i++) begin
      rd(kfc_pkg::ADDR_FIFO, d);
      chk(d, {(i < 15), 1'b0, 6'(i)}, "preserved event");
    end
    rd(kfc_pkg::ADDR_FIFO, d);
    chk(d, kfc_pkg::BYTE_EMPTY, "seventeenth event lost");
    $display("test overflow done");
    close_out();
  end
endmodule

// ===== verif/kfc_matrix_model.sv
`timescale 1ns/10ps
module kfc_matrix_model (
  // column side from the scanner
  input wire logic [7:0] col_o,
  input wire logic [7:0] col_oe_n,
  // switches held, index col*8+row
  input wire logic [63:0] key_down,
  // row pins as seen through the pull-ups
  output logic [7:0] row
);
  // an undriven column never pulls a row, so a released row reads the pull-up level
  always_comb begin
    row = 8'hFF;
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        if (key_down[c*8+r] && !col_oe_n[c] && !col_o[c]) row[r] = 1'b0;
      end
    end
  end
endmodule
